// >>> verilog/plned_pkg.sv
package plned_pkg;
   // -----------------------------------------------------------
   // character codes
   // -----------------------------------------------------------
   localparam logic [5:0] CODE_ESCAPE = 6'h3F;
   localparam logic [5:0] CODE_IGNORE = 6'h0F;
   localparam logic [5:0] CODE_SPACE = 6'h10;
   localparam logic [1:0] SKIP_TOP = 2'h2;
   localparam int LC_TOP_BIT = 5;
   localparam int LC_MODE_BIT = 4;
   localparam int SKIP_SHIFT = 3;
   localparam int BLANK_W = 7;
   localparam logic [3:0] TOP_OF_PAGE_N = 4'h0;
   localparam int LINE_MAX = 136;
   // -----------------------------------------------------------
   // print command op codes and paper motion selection
   // -----------------------------------------------------------
   localparam logic [5:0] OP_EDIT_BASE = 6'h18;
   localparam logic [5:0] OP_NONEDIT_BASE = 6'h08;
   localparam logic [1:0] ADV_NONE = 2'h0;
   localparam logic [1:0] ADV_SINGLE = 2'h1;
   localparam logic [1:0] ADV_DOUBLE = 2'h2;
   localparam logic [1:0] ADV_TOP = 2'h3;
   // -----------------------------------------------------------
   // states
   // -----------------------------------------------------------
   typedef enum logic [1:0] {
      ESC_NONE = 2'h0,
      ESC_ONE = 2'h1,
      ESC_TWO = 2'h3
   } plned_esc_type;
   typedef enum logic [1:0] {
      PH_IDLE = 2'h0,
      PH_RECV = 2'h1,
      PH_DRAIN = 2'h3,
      PH_ADV = 2'h2
   } plned_phase_type;
endpackage : plned_pkg

// >>> verilog/plned_decoder.sv
`timescale 1ns/1ns
module plned_decoder (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // print command
   input wire logic cmd_valid,
   input wire logic [5:0] cmd_op,
   // print-line characters from the channel
   input wire logic char_valid,
   input wire logic [5:0] char_data,
   output logic char_ready,
   input wire logic xfer_end,
   // printable characters to the print mechanism
   output logic prn_valid,
   output logic [5:0] prn_char,
   input wire logic prn_ready,
   // vertical_format_tape_reader, sampled at each new paper position
   input wire logic tape_step,
   input wire logic [3:0] tape_punch,
   input wire logic tape_ch5,
   input wire logic tape_ch6,
   // paper motion and line status
   output logic paper_move,
   output logic line_done,
   output logic busy
);
   import plned_pkg::*;

   // -----------------------------------------------------------
   // functions
   // -----------------------------------------------------------
   function automatic logic [BLANK_W-1:0] skip_blanks(input logic [3:0] bits);
      skip_blanks = BLANK_W'({bits, 3'h0});
   endfunction : skip_blanks

   function automatic logic op_is_print(input logic [5:0] op);
      op_is_print = (op[5:2] == OP_EDIT_BASE[5:2]) ||
                    (op[5:2] == OP_NONEDIT_BASE[5:2]);
   endfunction : op_is_print

   // -----------------------------------------------------------
   // state
   // -----------------------------------------------------------
   plned_phase_type phase_r, phase_nxt;
   plned_esc_type esc_r, esc_nxt;
   logic edit_r, edit_nxt;
   logic [BLANK_W-1:0] blank_r, blank_nxt;
   logic tape_mode_r, tape_mode_nxt;
   logic [3:0] adv_n_r, adv_n_nxt;
   logic inline_r, inline_nxt;
   logic auto_r, auto_nxt;
   logic done_r, done_nxt;
   logic ready_r, ready_nxt;
   logic move_r, move_nxt;
   logic line_done_r, line_done_nxt;
   logic busy_r, busy_nxt;
   logic [5:0] head_r, head_nxt, tail_r, tail_nxt;
   logic hv_r, hv_nxt, tv_r, tv_nxt;

   // -----------------------------------------------------------
   // character decode
   // -----------------------------------------------------------
   wire take = ready_r && char_valid;
   wire is_esc = (char_data == CODE_ESCAPE);
   wire is_ign = (char_data == CODE_IGNORE);
   wire is_lc = ~char_data[LC_TOP_BIT];
   wire is_skip = (char_data[5:4] == SKIP_TOP);
   wire lc_tape = char_data[LC_MODE_BIT];
   wire [3:0] lc_n = char_data[3:0];
   wire in_edit = edit_r;
   // what this character does, by escape depth
   wire lead_esc = take && in_edit && (esc_r == ESC_NONE) && is_esc;
   wire second_esc = take && in_edit && (esc_r == ESC_ONE) && is_esc;
   wire lc_hit = take && in_edit && (esc_r == ESC_ONE) && is_lc;
   wire skip_hit = take && in_edit && (esc_r == ESC_ONE) && is_skip;
   wire drop_ign = take && in_edit && (esc_r == ESC_NONE) && is_ign;
   // a single escape kills a following 11xxxx non-escape code
   wire drop_esc = take && in_edit && (esc_r == ESC_ONE) && !is_esc && !is_lc && !is_skip;
   // nonedit and forced characters print their own code; blank is the space code
   // every taken code that none of the decodes above swallows goes to print
   wire print_char = take && !(lead_esc || second_esc || lc_hit || skip_hit ||
                     drop_ign || drop_esc);
   wire line_end = (phase_r == PH_RECV) && (lc_hit || (xfer_end && !take) ||
                   (xfer_end && take && !lc_hit));

   // -----------------------------------------------------------
   // two-entry output buffer
   // -----------------------------------------------------------
   wire pop = hv_r && prn_ready;
   wire blank_push = (blank_r != '0) && (!tv_r || pop);
   wire push = print_char || blank_push;
   wire [5:0] push_char = print_char ? char_data : CODE_SPACE;
   wire buf_empty = !hv_r && !tv_r;

   // the tail only fills while the head is occupied,
   // so a stall never loses a word and order is kept
   always_comb begin
      head_nxt = head_r;
      tail_nxt = tail_r;
      hv_nxt = hv_r;
      tv_nxt = tv_r;
      if (pop || !hv_r) begin
         if (tv_r) begin
            head_nxt = tail_r;
            hv_nxt = 1'b1;
            tv_nxt = push;
            tail_nxt = push ? push_char : tail_r;
         end else begin
            head_nxt = push ? push_char : head_r;
            hv_nxt = push;
         end
      end else if (push) begin
         tail_nxt = push_char;
         tv_nxt = 1'b1;
      end
   end

   wire [1:0] fill_nxt = {1'b0, hv_nxt} + {1'b0, tv_nxt};

   // -----------------------------------------------------------
   // escape decoder
   // -----------------------------------------------------------
   always_comb begin
      esc_nxt = esc_r;
      if (phase_r != PH_RECV) begin
         esc_nxt = ESC_NONE;
      end else if (lead_esc) begin
         esc_nxt = ESC_ONE;
      end else if (second_esc) begin
         esc_nxt = ESC_TWO;
      end else if (take && in_edit) begin
         // the character after one or two escapes closes the sequence
         esc_nxt = ESC_NONE;
      end
   end

   // skip blanks count down one per pushed blank
   always_comb begin
      blank_nxt = blank_r;
      if (skip_hit) begin
         blank_nxt = skip_blanks(char_data[3:0]);
      end else if (blank_push) begin
         blank_nxt = blank_r - BLANK_W'(1);
      end
   end

   // -----------------------------------------------------------
   // paper advance tracking
   // -----------------------------------------------------------
   wire cnt_zero = (adv_n_r == 4'h0);
   wire [3:0] cnt_dec = cnt_zero ? 4'h0 : adv_n_r - 4'h1;
   wire prog_hit = tape_mode_r ? (tape_punch == adv_n_r) : (cnt_dec == 4'h0);
   wire step_done = done_r || prog_hit;
   // in-line advance only honours channel 5 where it stops
   wire auto_start = tape_ch5 && (!inline_r || (step_done && !done_r));
   wire step_auto = (auto_r && !tape_ch6) || (auto_start && !tape_ch6);
   wire adv_stop = step_done && !step_auto;
   // motion chosen when the line closes, used when the buffer has drained
   wire start_done = !tape_mode_r && cnt_zero;

   // -----------------------------------------------------------
   // line sequencing
   // -----------------------------------------------------------
   always_comb begin
      phase_nxt = phase_r;
      edit_nxt = edit_r;
      tape_mode_nxt = tape_mode_r;
      adv_n_nxt = adv_n_r;
      inline_nxt = inline_r;
      auto_nxt = auto_r;
      done_nxt = done_r;
      move_nxt = move_r;
      line_done_nxt = 1'b0;
      unique case (phase_r)
         PH_IDLE: begin
            if (cmd_valid && op_is_print(cmd_op)) begin
               phase_nxt = PH_RECV;
               edit_nxt = (cmd_op[5:2] == OP_EDIT_BASE[5:2]);
               inline_nxt = 1'b0;
               auto_nxt = 1'b0;
               // command's own paper motion, held unless the line overrides it
               tape_mode_nxt = (cmd_op[1:0] == ADV_TOP);
               unique case (cmd_op[1:0])
                  ADV_NONE: adv_n_nxt = 4'h0;
                  ADV_SINGLE: adv_n_nxt = 4'h1;
                  ADV_DOUBLE: adv_n_nxt = 4'h2;
                  ADV_TOP: adv_n_nxt = TOP_OF_PAGE_N;
               endcase
            end
         end
         PH_RECV: begin
            if (lc_hit) begin
               tape_mode_nxt = lc_tape;
               adv_n_nxt = lc_n;
               inline_nxt = 1'b1;
            end
            if (line_end) begin
               phase_nxt = PH_DRAIN;
            end
         end
         PH_DRAIN: begin
            // printing always finishes before paper moves
            if (buf_empty && (blank_r == '0)) begin
               done_nxt = start_done;
               if (start_done) begin
                  phase_nxt = PH_IDLE;
                  line_done_nxt = 1'b1;
               end else begin
                  phase_nxt = PH_ADV;
                  move_nxt = 1'b1;
               end
            end
         end
         PH_ADV: begin
            if (tape_step) begin
               if (!tape_mode_r) begin
                  adv_n_nxt = cnt_dec;
               end
               done_nxt = step_done;
               auto_nxt = step_auto;
               if (adv_stop) begin
                  phase_nxt = PH_IDLE;
                  move_nxt = 1'b0;
                  line_done_nxt = 1'b1;
               end
            end
         end
      endcase
   end

   // registered ready: at most one push lands per cycle, so one free slot suffices
   assign ready_nxt = (phase_nxt == PH_RECV) && (blank_nxt == '0) && (fill_nxt != 2'h2);
   assign busy_nxt = (phase_nxt != PH_IDLE);

   // -----------------------------------------------------------
   // registers
   // -----------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         phase_r <= PH_IDLE;
         esc_r <= ESC_NONE;
         edit_r <= 1'b0;
         blank_r <= '0;
         tape_mode_r <= 1'b0;
         adv_n_r <= 4'h0;
         inline_r <= 1'b0;
         auto_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
         esc_r <= esc_nxt;
         edit_r <= edit_nxt;
         blank_r <= blank_nxt;
         tape_mode_r <= tape_mode_nxt;
         adv_n_r <= adv_n_nxt;
         inline_r <= inline_nxt;
         auto_r <= auto_nxt;
         done_r <= done_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         head_r <= 6'h00;
         tail_r <= 6'h00;
         hv_r <= 1'b0;
         tv_r <= 1'b0;
         ready_r <= 1'b0;
         move_r <= 1'b0;
         line_done_r <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         head_r <= head_nxt;
         tail_r <= tail_nxt;
         hv_r <= hv_nxt;
         tv_r <= tv_nxt;
         ready_r <= ready_nxt;
         move_r <= move_nxt;
         line_done_r <= line_done_nxt;
         busy_r <= busy_nxt;
      end
   end

   // -----------------------------------------------------------
   // outputs
   // -----------------------------------------------------------
   assign char_ready = ready_r;
   assign prn_valid = hv_r;
   assign prn_char = head_r;
   assign paper_move = move_r;
   assign line_done = line_done_r;
   assign busy = busy_r;

endmodule : plned_decoder

// >>> verif/plned_decoder_assertions.sv
`timescale 1ns/1ns
module plned_decoder_assertions (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // command and channel
   input wire logic cmd_valid,
   input wire logic [5:0] cmd_op,
   input wire logic char_ready,
   input wire logic xfer_end,
   // print side and paper
   input wire logic prn_valid,
   input wire logic [5:0] prn_char,
   input wire logic prn_ready,
   input wire logic tape_step,
   input wire logic paper_move,
   input wire logic line_done,
   input wire logic busy
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire op_ok = cmd_op inside {[6'h08:6'h0B], [6'h18:6'h1B]};
   sequence s_cmd_taken;
      cmd_valid && op_ok && !busy;
   endsequence
   sequence s_done_pulse;
      line_done && !busy && !paper_move ##1 !line_done;
   endsequence
   property p_reset;
      @(posedge ref_clk) disable iff (1'b0)
      !rst_n |=> !busy && !prn_valid && !paper_move && !line_done && !char_ready;
   endproperty
   property p_cmd_start;
      s_cmd_taken |=> busy && char_ready;
   endproperty
   property p_bad_op;
      cmd_valid && !op_ok && !busy |=> !busy;
   endproperty
   property p_xfer_end;
      busy && xfer_end |=> !char_ready;
   endproperty
   property p_stop;
      $fell(paper_move) |-> $past(tape_step) && line_done;
   endproperty
   property p_done;
      line_done |-> s_done_pulse;
   endproperty
   property p_prn_hold;
      prn_valid && !prn_ready |=> prn_valid && $stable(prn_char);
   endproperty
   property p_adv;
      $rose(paper_move) |-> !prn_valid && !char_ready && busy;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not cleared");
   a_cmd_start: assert property (p_cmd_start) else $error("command not taken");
   a_bad_op: assert property (p_bad_op) else $error("bad op taken");
   a_xfer_end: assert property (p_xfer_end) else $error("line not ended");
   a_stop: assert property (p_stop) else $error("stop without step");
   a_done: assert property (p_done) else $error("bad done pulse");
   a_prn_hold: assert property (p_prn_hold) else $error("print char lost");
   a_adv: assert property (p_adv) else $error("advance before print");
endmodule : plned_decoder_assertions

bind plned_decoder plned_decoder_assertions plned_decoder_assertions_i (
   .ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
   .char_ready(char_ready), .xfer_end(xfer_end), .prn_valid(prn_valid),
   .prn_char(prn_char), .prn_ready(prn_ready), .tape_step(tape_step),
   .paper_move(paper_move), .line_done(line_done), .busy(busy)
);

// >>> verif/plned_chan_model.sv
`timescale 1ns/1ns
module plned_chan_model (
   // clock
   input wire logic ref_clk,
   // character handshake
   input wire logic char_ready,
   output logic char_valid,
   output logic [5:0] char_data,
   output logic xfer_end
);
   // the bench loads whole lines of at most 3 characters
   logic [5:0] q[$];
   logic end_req = 1'b0;
   logic slow = 1'b0;
   initial begin
      char_valid = 1'b0;
      char_data = 6'h2A;
      xfer_end = 1'b0;
   end
   always @(posedge ref_clk) begin : drive
      logic took;
      took = char_valid && char_ready;
      if (took) q.delete(0);
      #1;
      xfer_end = 1'b0;
      if (q.size() > 0 && !(slow && took)) begin
         char_valid = 1'b1;
         char_data = q[0];
      end else begin
         // released data must not keep its last value
         if (char_valid) char_data = ~char_data;
         char_valid = 1'b0;
         if (took && q.size() == 0 && end_req) begin
            xfer_end = 1'b1;
            end_req = 1'b0;
         end
      end
   end
endmodule : plned_chan_model

// >>> verif/tb_plned_decoder.sv
`timescale 1ns/1ns
module tb_plned_decoder;
   import plned_pkg::*;
   typedef struct {logic [5:0] op; logic [17:0] cin; logic [17:0] ex; int n;} plned_row_type;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_valid = 1'b0;
   logic [5:0] cmd_op = 6'h00;
   logic prn_ready = 1'b1;
   logic tape_step = 1'b0;
   logic stall = 1'b0;
   logic auto_en = 1'b0;
   logic [7:0] pos = 8'h00;
   logic char_valid, char_ready, xfer_end, prn_valid, paper_move, line_done, busy;
   logic [5:0] char_data, prn_char;
   int n_mismatch = 0;
   int check_count = 0;
   int cyc = 0;
   int tcnt = 0;
   int lines = 0;
   logic [5:0] got[$];
   plned_row_type rows[9] = '{
      '{6'h18, {6'h3F, 6'h31, 6'h01}, 18'h01000, 1},
      '{6'h19, {6'h3F, 6'h3F, 6'h3F}, 18'h3F000, 1},
      '{6'h1A, {6'h0F, 6'h01, 6'h10}, 18'h01400, 2},
      '{6'h1B, {6'h3F, 6'h3F, 6'h0F}, 18'h0F000, 1},
      '{6'h18, {6'h3F, 6'h3F, 6'h10}, 18'h10000, 1},
      '{6'h08, {6'h3F, 6'h0F, 6'h10}, {6'h3F, 6'h0F, 6'h10}, 3},
      '{6'h09, {6'h05, 6'h20, 6'h3F}, {6'h05, 6'h20, 6'h3F}, 3},
      '{6'h0A, {6'h10, 6'h10, 6'h2A}, {6'h10, 6'h10, 6'h2A}, 3},
      '{6'h0B, {6'h21, 6'h3F, 6'h3F}, {6'h21, 6'h3F, 6'h3F}, 3}
   };
   // ---------------------------------------------------------------
   // design, channel and tape
   // ---------------------------------------------------------------
   plned_decoder plned_decoder_i (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .char_valid(char_valid), .char_data(char_data),
      .char_ready(char_ready), .xfer_end(xfer_end), .prn_valid(prn_valid),
      .prn_char(prn_char), .prn_ready(prn_ready), .tape_step(tape_step),
      .tape_punch(pos[3:0]), .tape_ch5(auto_en && pos[3:0] == 4'h4),
      .tape_ch6(pos[3:0] == 4'h9), .paper_move(paper_move), .line_done(line_done),
      .busy(busy));
   plned_chan_model plned_chan_model_i (.ref_clk(ref_clk), .char_ready(char_ready),
      .char_valid(char_valid), .char_data(char_data), .xfer_end(xfer_end));
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (prn_valid && prn_ready) got.push_back(prn_char);
      #1;
      // a stalling printer takes one char in four so the buffer fills
      prn_ready = !stall || cyc % 4 == 0;
      tcnt = paper_move ? tcnt + 1 : 0;
      tape_step = tcnt % 4 == 3;
      if (tape_step) begin
         pos++;
         lines++;
      end
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         complete_run();
      end
   end
   // ---------------------------------------------------------------
   // expected paper travel, walked line by line over the tape loop
   // ---------------------------------------------------------------
   function automatic int adv(input int n, input logic tape, input logic inl);
      int p = pos;
      int k = 0;
      logic au = 1'b0;
      logic dn = 1'b0;
      logic nw;
      if (!tape && n == 0) return 0;
      do begin
         p++;
         k++;
         nw = !dn && (tape ? p % 16 == n : k >= n);
         dn = dn || nw;
         if (p % 16 == 9) au = 1'b0;
         else if (p % 16 == 4 && auto_en && (!inl || nw)) au = 1'b1;
      end while (au || !dn);
      return k;
   endfunction : adv
   task automatic chk_c(input string what, input logic [5:0] ex, input logic [5:0] seen);
      check_count++;
      if (seen !== ex) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, ex, seen);
      end
   endtask : chk_c
   task automatic chk_n(input string what, input int ex, input int seen);
      check_count++;
      if (seen != ex) begin
         n_mismatch++;
         $display("[ERR] %s expected %0d seen %0d", what, ex, seen);
      end
   endtask : chk_n
   task automatic line(input logic [5:0] op, input logic [35:0] cs, input int nc,
      input int e, input int np);
      int k;
      got.delete();
      lines = 0;
      for (k = 0; k < nc; k++) plned_chan_model_i.q.push_back(cs[35-6*k -: 6]);
      plned_chan_model_i.end_req = 1'b1;
      @(posedge ref_clk);
      #1 cmd_valid = 1'b1;
      cmd_op = op;
      @(posedge ref_clk);
      #1 cmd_valid = 1'b0;
      for (k = 0; k < 2000 && line_done !== 1'b1; k++) begin
         @(posedge ref_clk);
         #1;
      end
      chk_n("line done", 1, int'(line_done === 1'b1));
      chk_n("lines", e, lines);
      chk_n("prints", np, got.size());
   endtask : line
   task automatic complete_run();
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : complete_run
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      int i, e;
      repeat (6) @(posedge ref_clk);
      #1;
      chk_c("reset", 6'h00, {1'b0, busy, prn_valid, paper_move, line_done, char_ready});
      rst_n = 1'b1;
      cmd_valid = 1'b1;
      cmd_op = 6'h31;
      @(posedge ref_clk);
      #1 cmd_valid = 1'b0;
      @(posedge ref_clk);
      #1 chk_c("bad op", 6'h00, {5'h00, busy});
      foreach (rows[i]) begin
         e = rows[i].op[1:0] == ADV_TOP ? adv(0, 1, 0) : adv(rows[i].op[1:0], 0, 0);
         line(rows[i].op, {rows[i].cin, 18'h0}, 3, e, rows[i].n);
         for (int j = 0; j < rows[i].n; j++) chk_c("char", rows[i].ex[17-6*j -: 6], got[j]);
      end
      auto_en = 1'b1;
      line(6'h18, {6'h3F, 6'h13, 24'h0}, 2, adv(3, 1, 1), 0);
      line(6'h19, {6'h01, 30'h0}, 1, adv(1, 0, 0), 1);
      line(6'h18, {6'h3F, 6'h12, 24'h0}, 2, adv(2, 1, 1), 0);
      line(6'h1B, {6'h02, 30'h0}, 1, adv(0, 1, 0), 1);
      line(6'h1B, {6'h3F, 6'h04, 24'h0}, 2, adv(4, 0, 1), 0);
      line(6'h18, {6'h3F, 6'h0F, 24'h0}, 2, adv(15, 0, 1), 0);
      line(6'h18, {6'h3F, 6'h10, 24'h0}, 2, adv(0, 1, 1), 0);
      line(6'h1B, {6'h3F, 6'h00, 24'h0}, 2, 0, 0);
      stall = 1'b1;
      plned_chan_model_i.slow = 1'b1;
      line(6'h18, {6'h3F, 6'h2F, 6'h01, 18'h0}, 3, 0, 121);
      chk_c("skip", 6'h10, got[119]);
      chk_c("after skip", 6'h01, got[120]);
      line(6'h18, {6'h3F, 6'h21, 6'h10, 18'h0}, 3, 0, 9);
      stall = 1'b0;
      line(6'h18, {6'h3F, 30'h0}, 1, 0, 0);
      line(6'h18, {6'h01, 30'h0}, 1, 0, 1);
      chk_c("new line", 6'h01, got[0]);
      // reset in mid-line with an escape pending must leave no trace
      plned_chan_model_i.q.push_back(6'h3F);
      @(posedge ref_clk);
      #1 cmd_valid = 1'b1;
      cmd_op = 6'h18;
      @(posedge ref_clk);
      #1 cmd_valid = 1'b0;
      repeat (3) @(posedge ref_clk);
      #1 chk_c("escape pending", 6'h01, {5'h00, busy});
      rst_n = 1'b0;
      @(posedge ref_clk);
      #1 rst_n = 1'b1;
      chk_c("mid reset", 6'h00, {1'b0, busy, prn_valid, paper_move, line_done, char_ready});
      line(6'h18, {6'h01, 30'h0}, 1, 0, 1);
      chk_c("after reset", 6'h01, got[0]);
      complete_run();
   end
endmodule : tb_plned_decoder
